// ### src/ctq_params.svh
// Offsets, field positions, reset values and limits of the CAN transmit queue block
`ifndef CTQ_PARAMS_SVH
`define CTQ_PARAMS_SVH

// Register byte offsets
`define CTQ_OFS_CONFIG 12'h000
`define CTQ_OFS_STATE 12'h010
`define CTQ_OFS_PTR 12'h020
`define CTQ_OFS_CHAN 12'h030
`define CTQ_OFS_SRC 12'h034
`define CTQ_OFS_IDENT 12'h038

// queue_config fields
`define CTQ_CFG_ON 0
`define CTQ_CFG_IRQ_EN 1
`define CTQ_CFG_IRQ_MODE 2
`define CTQ_CFG_FRAME_EN 3
`define CTQ_CFG_DEPTH_LO 8
`define CTQ_CFG_DEPTH_HI 12

// queue_state fields
`define CTQ_ST_EMPTY 0
`define CTQ_ST_FULL 1
`define CTQ_ST_IRQ 2
`define CTQ_ST_FRAME 3
`define CTQ_ST_CNT_LO 8
`define CTQ_ST_CNT_HI 13

// Channel control fields
`define CTQ_CH_MODE_LO 0
`define CTQ_CH_MODE_HI 1
`define CTQ_CH_HIST 2
`define CTQ_CH_SMALL 3

// Staged identifier fields
`define CTQ_ID_HI 28
`define CTQ_ID_HIST 31

// Values and limits
`define CTQ_ADVANCE_KEY 8'hff
`define CTQ_MIN_DEPTH 5'h02
`define CTQ_MAX_LARGE 6'h20
`define CTQ_MAX_SMALL 6'h10
`define CTQ_RST_DEPTH 5'h00
`define CTQ_RST_MODE 2'h2

`endif

// ### src/ctq_pkg.sv
// Types shared by the CAN transmit queue block
package ctq_pkg;
  localparam int CTQ_QUEUES = 4;
  localparam int CTQ_SLOTS = 32;

  typedef enum logic [1:0] {
    CTQ_MODE_COMM = 2'h0,
    CTQ_MODE_HALT = 2'h1,
    CTQ_MODE_RESET = 2'h2,
    CTQ_MODE_SLEEP = 2'h3
  } ctq_chmode_t;

  // Gray along idle -> offer -> busy
  typedef enum logic [1:0] {
    CTQ_IDLE = 2'b00,
    CTQ_OFFER = 2'b01,
    CTQ_BUSY = 2'b11
  } ctq_state_t;

  typedef struct packed {
    logic hist;
    logic [28:0] id;
  } ctq_msg_t;

  typedef struct packed {
    logic req;
    logic [1:0] queue;
    logic [4:0] slot;
    ctq_msg_t msg;
  } ctq_txreq_t;
endpackage

// ### src/ctq_queue.sv
// One transmit queue: slot storage, count, full/empty and best-identifier search
`timescale 1ns/10ps
`default_nettype none
module ctq_queue
  import ctq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic push,
  input wire ctq_msg_t push_msg,
  input wire logic pop,
  input wire logic [4:0] pop_slot,
  input wire logic flush,
  input wire logic [5:0] alloc,
  // Status
  output logic [5:0] count,
  output logic full,
  output logic empty,
  output logic best_valid,
  output logic [4:0] best_slot,
  output ctq_msg_t best_msg
);
  ctq_msg_t slot_msg [CTQ_SLOTS];
  logic [CTQ_SLOTS-1:0] valid;
  logic [CTQ_SLOTS-1:0] next_valid;
  logic [5:0] next_count;
  logic [4:0] free_slot;

  always_comb begin
    free_slot = 5'h00;
    for (int i = CTQ_SLOTS - 1; i >= 0; i--) begin
      if (!valid[i]) begin
        free_slot = 5'(i);
      end
    end
    best_valid = 1'b0;
    best_slot = 5'h00;
    best_msg = '0;
    // Lowest identifier wins; ties keep the lower slot, not the store order
    for (int i = 0; i < CTQ_SLOTS; i++) begin
      if (valid[i] && (!best_valid || slot_msg[i].id < best_msg.id)) begin
        best_valid = 1'b1;
        best_slot = 5'(i);
        best_msg = slot_msg[i];
      end
    end
  end

  always_comb begin
    next_valid = valid;
    next_count = count;
    if (flush) begin
      next_valid = '0;
      next_count = 6'h00;
    end else begin
      if (pop) begin
        next_valid[pop_slot] = 1'b0;
      end
      if (push) begin
        next_valid[free_slot] = 1'b1;
      end
      next_count = 6'(count + {5'h00, push} - {5'h00, pop});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= '0;
      count <= 6'h00;
    end else begin
      valid <= next_valid;
      count <= next_count;
    end
  end

  always_ff @(posedge pclk) begin
    if (push && !flush) begin
      slot_msg[free_slot] <= push_msg;
    end
  end

  assign full = (count >= alloc);
  assign empty = (count == 6'h00);
endmodule
`default_nettype wire

// ### src/ctq_top.sv
// CAN channel transmit queues with APB register access and protocol engine handshake
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ctq_params.svh"
module ctq_top
  import ctq_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol engine
  output ctq_txreq_t tx_req,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_fail,
  output logic hist_store,
  // Channel transmit interrupt
  output logic tx_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] q_on, q_ie, q_im, q_fie, q_flag, q_fflag;
  logic [4:0] q_depth [CTQ_QUEUES];
  ctq_chmode_t ch_mode;
  logic ch_hist, ch_small;
  ctq_msg_t staged;
  logic [3:0] next_on, next_ie, next_im, next_fie, next_flag, next_fflag;
  logic [4:0] next_depth [CTQ_QUEUES];
  ctq_chmode_t next_mode;
  logic next_hist, next_small;
  ctq_msg_t next_staged;
  logic [5:0] q_count [CTQ_QUEUES];
  logic [5:0] q_alloc [CTQ_QUEUES];
  logic [3:0] q_full, q_empty, q_bvalid, q_push, q_pop, q_flush;
  logic [4:0] q_bslot [CTQ_QUEUES];
  ctq_msg_t q_bmsg [CTQ_QUEUES];
  logic wr_acc, rd_setup;
  logic [3:0] wr_idx;
  ctq_state_t state, next_state;
  ctq_txreq_t next_req;
  logic next_hist_store, next_irq;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [3:0] sent, sent_last;

  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign wr_idx = paddr[5:2];

  ////////////////////////////////////////////////////////////////////////////
  // Queues
  genvar g;
  generate
    for (g = 0; g < CTQ_QUEUES; g++) begin : gen_q
      logic [5:0] cap;
      assign cap = ch_small ? `CTQ_MAX_SMALL : `CTQ_MAX_LARGE;
      assign q_alloc[g] = ({1'b0, q_depth[g]} > cap) ? cap : {1'b0, q_depth[g]};
      // Pointer advance is one entry per ff write, ignored when off or full
      assign q_push[g] = wr_acc && paddr[11:2] == 10'((`CTQ_OFS_PTR >> 2) + g) &&
        pwdata[7:0] == `CTQ_ADVANCE_KEY && q_on[g] && !q_full[g];
      assign sent[g] = state == CTQ_BUSY && tx_done && tx_req.queue == 2'(g);
      assign sent_last[g] = sent[g] && q_count[g] == 6'h01;
      assign q_pop[g] = sent[g];
      // Never flush under a chosen or running frame, or the engine loses its slot
      assign q_flush[g] = !q_on[g] && !(state != CTQ_IDLE && tx_req.queue == 2'(g));
      ctq_queue u_queue (
        .pclk(pclk),
        .presetn(presetn),
        .push(q_push[g]),
        .push_msg(staged),
        .pop(q_pop[g]),
        .pop_slot(tx_req.slot),
        .flush(q_flush[g]),
        .alloc(q_alloc[g]),
        .count(q_count[g]),
        .full(q_full[g]),
        .empty(q_empty[g]),
        .best_valid(q_bvalid[g]),
        .best_slot(q_bslot[g]),
        .best_msg(q_bmsg[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_comb begin
    next_on = q_on;
    next_ie = q_ie;
    next_im = q_im;
    next_fie = q_fie;
    next_depth = q_depth;
    next_mode = ch_mode;
    next_hist = ch_hist;
    next_small = ch_small;
    next_staged = staged;
    next_flag = q_flag;
    next_fflag = q_fflag;
    if (wr_acc) begin
      if (paddr[11:4] == 8'(`CTQ_OFS_CONFIG >> 4)) begin
        next_ie[wr_idx[1:0]] = pwdata[`CTQ_CFG_IRQ_EN];
        next_im[wr_idx[1:0]] = pwdata[`CTQ_CFG_IRQ_MODE];
        next_fie[wr_idx[1:0]] = pwdata[`CTQ_CFG_FRAME_EN];
        if (!q_on[wr_idx[1:0]]) begin
          next_depth[wr_idx[1:0]] = pwdata[`CTQ_CFG_DEPTH_HI:`CTQ_CFG_DEPTH_LO];
        end
        // Enable is written only in communication or halt mode; setting it also needs a valid allocation
        if ((ch_mode == CTQ_MODE_COMM || ch_mode == CTQ_MODE_HALT) &&
            (!pwdata[`CTQ_CFG_ON] || q_depth[wr_idx[1:0]] >= `CTQ_MIN_DEPTH)) begin
          next_on[wr_idx[1:0]] = pwdata[`CTQ_CFG_ON];
        end
      end
      if (paddr[11:4] == 8'(`CTQ_OFS_STATE >> 4)) begin
        // Writing 0 clears a flag; disabling never clears it
        next_flag[wr_idx[1:0]] = q_flag[wr_idx[1:0]] & pwdata[`CTQ_ST_IRQ];
        next_fflag[wr_idx[1:0]] = q_fflag[wr_idx[1:0]] & pwdata[`CTQ_ST_FRAME];
      end
      if (paddr == `CTQ_OFS_CHAN) begin
        next_mode = ctq_chmode_t'(pwdata[`CTQ_CH_MODE_HI:`CTQ_CH_MODE_LO]);
        next_hist = pwdata[`CTQ_CH_HIST];
        next_small = pwdata[`CTQ_CH_SMALL];
      end
      if (paddr == `CTQ_OFS_IDENT) begin
        next_staged.id = pwdata[`CTQ_ID_HI:0];
        next_staged.hist = pwdata[`CTQ_ID_HIST];
      end
    end
    // Channel reset mode drops every queue
    if (ch_mode == CTQ_MODE_RESET) begin
      next_on = 4'h0;
    end
    // Set wins over a clear in the same cycle
    for (int i = 0; i < CTQ_QUEUES; i++) begin
      if (q_ie[i] && (q_im[i] ? sent[i] : sent_last[i])) begin
        next_flag[i] = 1'b1;
      end
      if (q_fie[i] && sent[i]) begin
        next_fflag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_on <= 4'h0;
      q_ie <= 4'h0;
      q_im <= 4'h0;
      q_fie <= 4'h0;
      q_flag <= 4'h0;
      q_fflag <= 4'h0;
      q_depth <= '{default: `CTQ_RST_DEPTH};
      ch_mode <= ctq_chmode_t'(`CTQ_RST_MODE);
      ch_hist <= 1'b0;
      ch_small <= 1'b0;
      staged <= '0;
    end else begin
      q_on <= next_on;
      q_ie <= next_ie;
      q_im <= next_im;
      q_fie <= next_fie;
      q_flag <= next_flag;
      q_fflag <= next_fflag;
      q_depth <= next_depth;
      ch_mode <= next_mode;
      ch_hist <= next_hist;
      ch_small <= next_small;
      staged <= next_staged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data is fetched in the setup cycle so the access needs no wait
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (rd_setup) begin
      unique case (paddr[11:4])
        8'h00: begin
          next_prdata[`CTQ_CFG_ON] = q_on[paddr[3:2]];
          next_prdata[`CTQ_CFG_IRQ_EN] = q_ie[paddr[3:2]];
          next_prdata[`CTQ_CFG_IRQ_MODE] = q_im[paddr[3:2]];
          next_prdata[`CTQ_CFG_FRAME_EN] = q_fie[paddr[3:2]];
          next_prdata[`CTQ_CFG_DEPTH_HI:`CTQ_CFG_DEPTH_LO] = q_depth[paddr[3:2]];
        end
        8'h01: begin
          next_prdata[`CTQ_ST_EMPTY] = q_empty[paddr[3:2]];
          next_prdata[`CTQ_ST_FULL] = q_full[paddr[3:2]];
          next_prdata[`CTQ_ST_IRQ] = q_flag[paddr[3:2]];
          next_prdata[`CTQ_ST_FRAME] = q_fflag[paddr[3:2]];
          next_prdata[`CTQ_ST_CNT_HI:`CTQ_ST_CNT_LO] = q_count[paddr[3:2]];
        end
        8'h02: next_prdata = 32'h0000_0000;
        8'h03: begin
          unique case (paddr[3:0])
            4'h0: next_prdata = {28'h000_0000, ch_small, ch_hist, ch_mode};
            4'h4: next_prdata = {24'h00_0000, q_fflag, q_flag};
            4'h8: next_prdata = {staged.hist, 2'h0, staged.id};
            default: next_slverr = 1'b1;
          endcase
        end
        default: next_slverr = 1'b1;
      endcase
      if (paddr[1:0] != 2'h0) begin
        next_slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_slverr;
      pready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit selection and engine handshake
  always_comb begin
    next_state = state;
    next_req = tx_req;
    next_hist_store = 1'b0;
    unique case (state)
      CTQ_IDLE: begin
        next_req.req = 1'b0;
        for (int i = 0; i < CTQ_QUEUES; i++) begin
          if (q_on[i] && q_bvalid[i] && (!next_req.req || q_bmsg[i].id < next_req.msg.id)) begin
            next_req = '{req: 1'b1, queue: 2'(i), slot: q_bslot[i], msg: q_bmsg[i]};
          end
        end
        if (next_req.req) begin
          next_state = CTQ_OFFER;
        end
      end
      CTQ_OFFER: begin
        if (tx_fail) begin
          next_state = CTQ_IDLE;
          next_req.req = 1'b0;
        end else if (tx_start) begin
          next_state = CTQ_BUSY;
        end
      end
      CTQ_BUSY: begin
        if (tx_done || tx_fail) begin
          next_state = CTQ_IDLE;
          next_req.req = 1'b0;
          next_hist_store = tx_done && ch_hist && tx_req.msg.hist;
        end
      end
      default: begin
        next_state = CTQ_IDLE;
        next_req.req = 1'b0;
      end
    endcase
    next_irq = |((next_flag & q_ie) | (next_fflag & q_fie));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CTQ_IDLE;
      tx_req <= '0;
      hist_store <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      state <= next_state;
      tx_req <= next_req;
      hist_store <= next_hist_store;
      tx_irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  generate
    for (g = 0; g < CTQ_QUEUES; g++) begin : gen_chk
      abort_empty_a: assert property (!q_on[g] && state == CTQ_IDLE |=> q_empty[g])
        else $error("disabled idle queue not empty");
      keep_flag_a: assert property ($fell(q_on[g]) && $past(q_flag[g]) |-> q_flag[g])
        else $error("queue flag lost on disable");
      frame_flag_a: assert property (sent[g] && q_fie[g] |=> q_fflag[g] && tx_irq)
        else $error("one-frame flag or interrupt missing");
      flag_cause_a: assert property ($rose(q_flag[g]) |-> $past(sent[g]))
        else $error("queue flag set without a sent frame");
      advance_one_a: assert property (q_push[g] && !q_pop[g] && !q_flush[g] |=> q_count[g] == $past(q_count[g]) + 6'h01)
        else $error("pointer advance did not add one entry");
      full_cnt_a: assert property (q_count[g] <= q_alloc[g] || !q_on[g])
        else $error("queue count beyond allocation");
    end
  endgenerate

  irq_merge_a: assert property ((|(q_flag & q_ie)) ##1 (|(q_flag & q_ie)) |-> tx_irq)
    else $error("channel interrupt not raised");
  hist_cause_a: assert property (hist_store |-> $past(ch_hist && tx_req.msg.hist && tx_done))
    else $error("history record without both enables");
  offer_best_a: assert property ($rose(tx_req.req) |-> tx_req.msg.id <= $past(q_bmsg[0].id) || !$past(q_bvalid[0] && q_on[0]))
    else $error("offered message not lowest identifier");
endmodule
`default_nettype wire

// ### test/ctq_engine_model.sv
// Protocol engine stand-in: takes offered frames, sends or fails them, logs what went out
`timescale 1ns/10ps
`default_nettype none
module ctq_engine_model
  import ctq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Queue handshake
  input wire ctq_txreq_t tx_req,
  output logic tx_start,
  output logic tx_done,
  output logic tx_fail,
  // Bench control
  input wire logic hold,
  input wire logic fail_next,
  input wire logic [3:0] delay
);
  logic [28:0] sent[$];

  // Never skips a step: offer, start, then exactly one result
  initial begin
    tx_start = 1'b0;
    tx_done = 1'b0;
    tx_fail = 1'b0;
    forever begin
      @(posedge pclk);
      if (presetn === 1'b1 && tx_req.req === 1'b1 && hold === 1'b0) begin
        repeat (delay) @(posedge pclk);
        tx_start <= 1'b1;
        @(posedge pclk);
        tx_start <= 1'b0;
        if (fail_next === 1'b1) begin
          tx_fail <= 1'b1;
        end else begin
          repeat (2) @(posedge pclk);
          tx_done <= 1'b1;
        end
        @(posedge pclk);
        tx_done <= 1'b0;
        tx_fail <= 1'b0;
        if (fail_next !== 1'b1) begin
          sent.push_back(tx_req.msg.id);
        end
        // Offer lingers one cycle after the result; a stale one must not restart
        while (tx_req.req === 1'b1) @(posedge pclk);
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the CAN transmit queue block
`timescale 1ns/10ps
`default_nettype none
module tb
  import ctq_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic hold = 1'b0;
  logic fail_next = 1'b0;
  logic [3:0] delay = 4'h2;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, tx_start, tx_done, tx_fail, hist_store, tx_irq;
  ctq_txreq_t tx_req;
  int failures = 0;
  int comparisons = 0;
  int hist_n = 0;

  always #20 pclk = ~pclk;

  ctq_top ctq_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_req(tx_req),
    .tx_start(tx_start), .tx_done(tx_done), .tx_fail(tx_fail), .hist_store(hist_store), .tx_irq(tx_irq));
  ctq_engine_model ctq_engine_model_i (.pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_start(tx_start),
    .tx_done(tx_done), .tx_fail(tx_fail), .hold(hold), .fail_next(fail_next), .delay(delay));

  always @(posedge pclk) begin
    if (hist_store === 1'b1) hist_n++;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Leading edge keeps a release and the next setup out of one time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a slave that never answers
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask

  task automatic push(input logic [1:0] q, input logic [28:0] id, input logic h);
    apb(1'b1, 12'h038, {h, 2'h0, id});
    apb(1'b1, {8'h02, q, 2'h0}, 32'h0000_00ff);
  endtask

  task automatic wait_sent(input int n);
    for (int i = 0; i < 3000; i++) begin
      if (ctq_engine_model_i.sent.size() >= n) break;
      @(posedge pclk);
    end
    check(32'(ctq_engine_model_i.sent.size() >= n), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(12'h000, 32'h0);
    rd_chk(12'h01c, 32'h3);
    rd_chk(12'h03c, 32'h0);
    check({31'h0, rerr}, 32'h1);
    apb(1'b1, 12'h000, 32'h401);
    rd_chk(12'h000, 32'h400);
    apb(1'b1, 12'h030, 32'h3);
    apb(1'b1, 12'h000, 32'h401);
    rd_chk(12'h000, 32'h400);
    apb(1'b1, 12'h030, 32'h5);
    rd_chk(12'h030, 32'h5);
    apb(1'b1, 12'h000, 32'h100);
    apb(1'b1, 12'h000, 32'h101);
    rd_chk(12'h000, 32'h100);
    apb(1'b1, 12'h000, 32'h400);
    apb(1'b1, 12'h000, 32'h401);
    rd_chk(12'h000, 32'h401);
    apb(1'b1, 12'h030, 32'h4);
    rd_chk(12'h030, 32'h4);
  endtask

  // First entry is locked under offer; the rest must leave by identifier
  task automatic t_priority();
    logic [31:0] exp_ids [4] = '{32'h1, 32'h100, 32'h200, 32'h300};
    hold <= 1'b1;
    push(2'h0, 29'h001, 1'b0);
    push(2'h0, 29'h300, 1'b0);
    push(2'h0, 29'h100, 1'b1);
    push(2'h0, 29'h200, 1'b0);
    apb(1'b1, 12'h020, 32'h7f);
    rd_chk(12'h010, 32'h402);
    push(2'h0, 29'h050, 1'b0);
    rd_chk(12'h010, 32'h402);
    rd_chk(12'h038, 32'h50);
    rd_chk(12'h020, 32'h0);
    hold <= 1'b0;
    wait_sent(4);
    foreach (exp_ids[i]) check({3'h0, ctq_engine_model_i.sent[i]}, exp_ids[i]);
    check(32'(hist_n), 32'h1);
    rd_chk(12'h010, 32'h1);
  endtask

  task automatic t_irq(input logic [1:0] q, input logic [31:0] cfg, mid, src, fin);
    int nb;
    nb = ctq_engine_model_i.sent.size();
    delay <= 4'h8;
    apb(1'b1, {8'h00, q, 2'h0}, cfg & 32'hffff_fffe);
    apb(1'b1, {8'h00, q, 2'h0}, cfg);
    hold <= 1'b1;
    push(q, 29'h20 + 29'(q), 1'b0);
    push(q, 29'h30 + 29'(q), 1'b0);
    hold <= 1'b0;
    wait_sent(nb + 1);
    rd_chk({8'h01, q, 2'h0}, mid);
    check({31'h0, tx_irq}, 32'h1);
    rd_chk(12'h034, src);
    wait_sent(nb + 2);
    rd_chk({8'h01, q, 2'h0}, fin);
    apb(1'b1, {8'h00, q, 2'h0}, cfg & 32'hffff_fffe);
    rd_chk({8'h01, q, 2'h0}, fin);
    apb(1'b1, {8'h01, q, 2'h0}, 32'h0);
    rd_chk({8'h01, q, 2'h0}, 32'h1);
    check({31'h0, tx_irq}, 32'h0);
  endtask

  // Small variant caps at 16; disabling under offer must drain all silently
  task automatic t_abort();
    int nb;
    nb = ctq_engine_model_i.sent.size();
    delay <= 4'h1;
    apb(1'b1, 12'h030, 32'h8);
    apb(1'b1, 12'h00c, 32'h1406);
    apb(1'b1, 12'h00c, 32'h1407);
    hold <= 1'b1;
    for (int i = 0; i < 17; i++) push(2'h3, 29'h400 + 29'(i), 1'b0);
    rd_chk(12'h01c, 32'h1002);
    apb(1'b1, 12'h00c, 32'h1406);
    fail_next <= 1'b1;
    hold <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, 12'h01c, 32'h0);
      if (rdata[0] === 1'b1) break;
    end
    check(rdata, 32'h1);
    check(32'(ctq_engine_model_i.sent.size()), 32'(nb));
    check({31'h0, tx_irq}, 32'h0);
    fail_next <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_priority();
    t_irq(2'h1, 32'h20b, 32'h108, 32'h20, 32'hd);
    t_irq(2'h2, 32'h207, 32'h104, 32'h4, 32'h5);
    t_abort();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
